// ===== hdl/tpl_probe_latch.sv
/*
  Two-channel touch-probe position latch with host object port.
  Assumes feedbackPosition is on clock; probe pins and the encoder
  index pin are asynchronous and are synchronised here.
*/
`timescale 1ns/100ps
module tpl_probe_latch (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Trigger pins
  input wire logic probe_input_one,
  input wire logic probe_input_two,
  input wire logic encoderIndex,
  // Feedback position
  input wire logic [31:0] feedbackPosition,
  // Host object port
  input wire logic objRead,
  input wire logic objWrite,
  input wire logic [15:0] objIndex,
  input wire logic [15:0] objWrData,
  output logic [31:0] objRdData_q,
  output logic objRdValid_q,
  output logic objError_q
);

  logic [15:0] probe_function_control_q;
  logic [15:0] probe_status_word;
  logic oneRise;
  logic oneFall;
  logic twoRise;
  logic twoFall;
  logic idxRise;
  logic idxFall;
  logic [1:0] trigRise;
  logic [1:0] trigFall;
  logic [1:0] riseHit;
  logic [1:0] fallHit;
  logic [1:0] chanOn;
  logic [1:0] riseStored_q;
  logic [1:0] fallStored_q;
  logic [1:0] execCount_q [2];
  logic [31:0] risePos_q [2];
  logic [31:0] fallPos_q [2];
  logic [7:0] cfg [2];

  // Field of one channel byte
  function automatic logic cfgBit(input logic [7:0] c, input int pos);
    cfgBit = c[pos];
  endfunction : cfgBit

  // Index decode, used by the write path, the error flag and the checks
  function automatic logic isIndex(input logic [15:0] idx, input logic [15:0] obj);
    isIndex = (idx == obj);
  endfunction : isIndex

  // Synchronisers and edge detectors
  tpl_edge_sync u_syncOne (
    .clock(clock),
    .sys_rst(sys_rst),
    .pinIn(probe_input_one),
    .risePulse(oneRise),
    .fallPulse(oneFall)
  );

  tpl_edge_sync u_syncTwo (
    .clock(clock),
    .sys_rst(sys_rst),
    .pinIn(probe_input_two),
    .risePulse(twoRise),
    .fallPulse(twoFall)
  );

  // Index shared by both channels, so one detector serves both
  tpl_edge_sync u_syncIdx (
    .clock(clock),
    .sys_rst(sys_rst),
    .pinIn(encoderIndex),
    .risePulse(idxRise),
    .fallPulse(idxFall)
  );

  // Function word, full 16 bits stored; reserved bits unused
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      probe_function_control_q <= tpl_pkg::FUNC_RESET;
    else if (objWrite && isIndex(objIndex, tpl_pkg::OBJ_FUNC))
      probe_function_control_q <= objWrData;
  end

  // Channel bytes
  assign cfg[0] = probe_function_control_q[0 +: tpl_pkg::CHAN_STRIDE];
  assign cfg[1] = probe_function_control_q[tpl_pkg::CHAN_STRIDE +: tpl_pkg::CHAN_STRIDE];

  // Trigger source select
  assign trigRise[0] = cfgBit(cfg[0], tpl_pkg::FN_INDEX_SRC) ? idxRise : oneRise;
  assign trigFall[0] = cfgBit(cfg[0], tpl_pkg::FN_INDEX_SRC) ? idxFall : oneFall;
  assign trigRise[1] = cfgBit(cfg[1], tpl_pkg::FN_INDEX_SRC) ? idxRise : twoRise;
  assign trigFall[1] = cfgBit(cfg[1], tpl_pkg::FN_INDEX_SRC) ? idxFall : twoFall;

  genvar ch;
  generate
    for (ch = 0; ch < tpl_pkg::CHAN_N; ch++)
    begin : g_chan
      assign chanOn[ch] = cfgBit(cfg[ch], tpl_pkg::FN_ENABLE);

      // Single mode blocks an edge type once it has stored
      assign riseHit[ch] = chanOn[ch] && trigRise[ch]
        && cfgBit(cfg[ch], tpl_pkg::FN_RISE_EN)
        && (cfgBit(cfg[ch], tpl_pkg::FN_CONT) || !riseStored_q[ch]);
      assign fallHit[ch] = chanOn[ch] && trigFall[ch]
        && cfgBit(cfg[ch], tpl_pkg::FN_FALL_EN)
        && (cfgBit(cfg[ch], tpl_pkg::FN_CONT) || !fallStored_q[ch]);

      // Rising result register
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          risePos_q[ch] <= tpl_pkg::POS_RESET;
        else if (riseHit[ch])
          risePos_q[ch] <= feedbackPosition;
      end

      // Falling result register
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          fallPos_q[ch] <= tpl_pkg::POS_RESET;
        else if (fallHit[ch])
          fallPos_q[ch] <= feedbackPosition;
      end

      // Stored flags; cleared only while disabled, when no hit can occur
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          riseStored_q[ch] <= 1'b0;
          fallStored_q[ch] <= 1'b0;
        end
        else if (!chanOn[ch])
        begin
          riseStored_q[ch] <= 1'b0;
          fallStored_q[ch] <= 1'b0;
        end
        else
        begin
          if (riseHit[ch])
            riseStored_q[ch] <= 1'b1;
          if (fallHit[ch])
            fallStored_q[ch] <= 1'b1;
        end
      end

      // Execution count; both edges in one cycle count once
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          execCount_q[ch] <= tpl_pkg::COUNT_RESET;
        else if (!chanOn[ch])
          execCount_q[ch] <= tpl_pkg::COUNT_RESET;
        else if (cfgBit(cfg[ch], tpl_pkg::FN_CONT) && (riseHit[ch] || fallHit[ch]))
          execCount_q[ch] <= execCount_q[ch] + tpl_pkg::COUNT_STEP;
      end

      // Status byte of this channel, built locally so each byte has one driver
      logic [7:0] statusByte;
      always_comb
      begin
        statusByte = 8'h00;
        statusByte[tpl_pkg::ST_ENABLED] = chanOn[ch];
        statusByte[tpl_pkg::ST_RISE_STORED] = riseStored_q[ch];
        statusByte[tpl_pkg::ST_FALL_STORED] = fallStored_q[ch];
        statusByte[tpl_pkg::ST_COUNT_LSB +: 2] = execCount_q[ch];
      end

      assign probe_status_word[ch*tpl_pkg::CHAN_STRIDE +: tpl_pkg::CHAN_STRIDE] = statusByte;

      // Checks
      sequence s_riseTaken;
        riseHit[ch] ##1 riseStored_q[ch];
      endsequence

      chk_rise_capture : assert property (@(posedge clock) disable iff (sys_rst)
        riseHit[ch] |=> risePos_q[ch] == $past(feedbackPosition))
        else $error("rising capture did not store position");

      chk_fall_capture : assert property (@(posedge clock) disable iff (sys_rst)
        fallHit[ch] |=> fallPos_q[ch] == $past(feedbackPosition) && fallStored_q[ch])
        else $error("falling capture did not store position");

      chk_rise_gate : assert property (@(posedge clock) disable iff (sys_rst)
        !cfgBit(cfg[ch], tpl_pkg::FN_RISE_EN) |=> $stable(risePos_q[ch]))
        else $error("rising result changed while rising edge disabled");

      chk_single_hold : assert property (@(posedge clock) disable iff (sys_rst)
        s_riseTaken ##0 (chanOn[ch] && !cfgBit(cfg[ch], tpl_pkg::FN_CONT))
        |=> $stable(risePos_q[ch]))
        else $error("single mode overwrote a stored result");

      chk_disable_clears : assert property (@(posedge clock) disable iff (sys_rst)
        !chanOn[ch] |=> probe_status_word[ch*tpl_pkg::CHAN_STRIDE +: 3] == 3'h0
        || chanOn[ch])
        else $error("disabled channel kept stored flags");

      chk_count_step : assert property (@(posedge clock) disable iff (sys_rst)
        chanOn[ch] && cfgBit(cfg[ch], tpl_pkg::FN_CONT) && (riseHit[ch] || fallHit[ch])
        |=> execCount_q[ch] == 2'($past(execCount_q[ch]) + tpl_pkg::COUNT_STEP))
        else $error("execution count did not step");

      chk_fall_gate : assert property (@(posedge clock) disable iff (sys_rst)
        !cfgBit(cfg[ch], tpl_pkg::FN_FALL_EN) |=> $stable(fallPos_q[ch]))
        else $error("falling result changed while falling edge disabled");

      chk_off_hold : assert property (@(posedge clock) disable iff (sys_rst)
        !chanOn[ch] |=> $stable(risePos_q[ch]) && $stable(fallPos_q[ch]))
        else $error("disabled channel changed a result");

      chk_rise_flag : assert property (@(posedge clock) disable iff (sys_rst)
        riseHit[ch] |=> riseStored_q[ch])
        else $error("rising capture did not set stored flag");

      chk_count_single : assert property (@(posedge clock) disable iff (sys_rst)
        chanOn[ch] && !cfgBit(cfg[ch], tpl_pkg::FN_CONT) |=> $stable(execCount_q[ch]))
        else $error("execution count moved in single mode");

      chk_status_spare : assert property (@(posedge clock) disable iff (sys_rst)
        probe_status_word[ch*tpl_pkg::CHAN_STRIDE + 3 +: 3] == 3'h0)
        else $error("reserved status bits not zero");

      chk_single_fall : assert property (@(posedge clock) disable iff (sys_rst)
        fallStored_q[ch] && chanOn[ch] && !cfgBit(cfg[ch], tpl_pkg::FN_CONT) |-> !fallHit[ch])
        else $error("single mode took a second falling capture");
    end
  endgenerate

  // Object read path, one-cycle registered answer
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      objRdData_q <= tpl_pkg::POS_RESET;
    else if (objRead)
    begin
      case (objIndex)
        tpl_pkg::OBJ_FUNC: objRdData_q <= {16'h0000, probe_function_control_q};
        tpl_pkg::OBJ_STATUS: objRdData_q <= {16'h0000, probe_status_word};
        tpl_pkg::OBJ_ONE_RISE: objRdData_q <= risePos_q[0];
        tpl_pkg::OBJ_ONE_FALL: objRdData_q <= fallPos_q[0];
        tpl_pkg::OBJ_TWO_RISE: objRdData_q <= risePos_q[1];
        tpl_pkg::OBJ_TWO_FALL: objRdData_q <= fallPos_q[1];
        default: objRdData_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      objRdValid_q <= 1'b0;
    else
      objRdValid_q <= objRead;
  end

  // Unknown index, or write to a read-only object
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      objError_q <= 1'b0;
    else
      objError_q <= (objRead && (objIndex < tpl_pkg::OBJ_FUNC || objIndex > tpl_pkg::OBJ_TWO_FALL))
        || (objWrite && !isIndex(objIndex, tpl_pkg::OBJ_FUNC));
  end

  sequence s_statusRead;
    objRead && isIndex(objIndex, tpl_pkg::OBJ_STATUS);
  endsequence

  chk_status_read : assert property (@(posedge clock) disable iff (sys_rst)
    s_statusRead |=> objRdValid_q && objRdData_q == {16'h0000, $past(probe_status_word)})
    else $error("status read answered wrong value");

  chk_func_write : assert property (@(posedge clock) disable iff (sys_rst)
    objWrite && isIndex(objIndex, tpl_pkg::OBJ_FUNC)
    |=> probe_function_control_q == $past(objWrData))
    else $error("function word write not stored");

  chk_src_select : assert property (@(posedge clock) disable iff (sys_rst)
    chanOn[0] && !cfg[0][tpl_pkg::FN_INDEX_SRC] && cfg[0][tpl_pkg::FN_RISE_EN]
    && cfg[0][tpl_pkg::FN_CONT] && oneRise
    |=> risePos_q[0] == $past(feedbackPosition))
    else $error("probe one rising edge not captured");

  chk_valid_follows : assert property (@(posedge clock) disable iff (sys_rst)
    objRead |=> objRdValid_q)
    else $error("read not answered in one cycle");

  chk_wr_refused : assert property (@(posedge clock) disable iff (sys_rst)
    objWrite && !isIndex(objIndex, tpl_pkg::OBJ_FUNC)
    |=> objError_q && $stable(probe_function_control_q))
    else $error("write to read-only object not refused");

  chk_unknown_read : assert property (@(posedge clock) disable iff (sys_rst)
    objRead && objIndex > tpl_pkg::OBJ_TWO_FALL |=> objError_q && objRdData_q == 32'h0000_0000)
    else $error("unknown read not refused");

  chk_one_enable : assert property (@(posedge clock) disable iff (sys_rst)
    probe_status_word[tpl_pkg::ST_ENABLED] == probe_function_control_q[tpl_pkg::FN_ENABLE])
    else $error("channel one enable status mismatched");

  chk_src_index : assert property (@(posedge clock) disable iff (sys_rst)
    chanOn[1] && cfg[1][tpl_pkg::FN_INDEX_SRC] && cfg[1][tpl_pkg::FN_RISE_EN]
    && cfg[1][tpl_pkg::FN_CONT] && idxRise
    |=> risePos_q[1] == $past(feedbackPosition))
    else $error("index rising edge not captured on channel two");

  chk_enable_status : assert property (@(posedge clock) disable iff (sys_rst)
    probe_status_word[tpl_pkg::CHAN_STRIDE] == probe_function_control_q[tpl_pkg::CHAN_STRIDE])
    else $error("channel two enable status mismatched");

endmodule : tpl_probe_latch

// ===== hdl/tpl_pkg.sv
/*
  Constants for the two-channel touch-probe position latch:
  object indices, control and status field positions, reset values.
  Assumes a 16-bit object index space on the host object port.
*/
package tpl_pkg;

  // Object indices on the host object port
  localparam logic [15:0] OBJ_FUNC = 16'h60B8;
  localparam logic [15:0] OBJ_STATUS = 16'h60B9;
  localparam logic [15:0] OBJ_ONE_RISE = 16'h60BA;
  localparam logic [15:0] OBJ_ONE_FALL = 16'h60BB;
  localparam logic [15:0] OBJ_TWO_RISE = 16'h60BC;
  localparam logic [15:0] OBJ_TWO_FALL = 16'h60BD;

  // Widths
  localparam int WORD_W = 16;
  localparam int POS_W = 32;
  localparam int CHAN_N = 2;
  localparam int CHAN_STRIDE = 8;

  // Function word field positions within one channel byte
  localparam int FN_ENABLE = 0;
  localparam int FN_CONT = 1;
  localparam int FN_INDEX_SRC = 2;
  localparam int FN_RISE_EN = 4;
  localparam int FN_FALL_EN = 5;

  // Status word field positions within one channel byte
  localparam int ST_ENABLED = 0;
  localparam int ST_RISE_STORED = 1;
  localparam int ST_FALL_STORED = 2;
  localparam int ST_COUNT_LSB = 6;

  // Reset values and count step
  localparam logic [15:0] FUNC_RESET = 16'h0000;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  localparam logic [1:0] COUNT_RESET = 2'h0;
  localparam logic [1:0] COUNT_STEP = 2'h1;

endpackage : tpl_pkg

// ===== hdl/tpl_edge_sync.sv
/*
  Two-flop synchroniser with edge detector for one probe or encoder index pin.
  Assumes the pin is asynchronous to clock; edges closer than
  one clock period apart may merge.
*/
`timescale 1ns/100ps
module tpl_edge_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Pin side
  input wire logic pinIn,
  // Edge pulses
  output logic risePulse,
  output logic fallPulse
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // First flop feeds only the second
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= pinIn;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      prev_q <= 1'b0;
    else
      prev_q <= sync_q;
  end

  // One pulse per settled edge
  assign risePulse = sync_q & ~prev_q;
  assign fallPulse = ~sync_q & prev_q;

  // A one-cycle pin glitch may give a rise then a fall; only repeats of one kind are wrong
  chk_pulse_single : assert property (@(posedge clock) disable iff (sys_rst)
    (risePulse |=> !risePulse) and (fallPulse |=> !fallPulse))
    else $error("edge pulse lasted more than one cycle");

endmodule : tpl_edge_sync

// ===== tb/tpl_host_model.sv
/*
  Host controller model for the probe latch object port.
  Assumes one clock shared with the latch; requests change 1 ns after an edge.
*/
`timescale 1ns/100ps
module tpl_host_model (
  // Clock
  input wire logic clock,
  // Object port
  output logic objRead,
  output logic objWrite,
  output logic [15:0] objIndex,
  output logic [15:0] objWrData,
  input wire logic [31:0] objRdData_q,
  input wire logic objRdValid_q,
  input wire logic objError_q
);
  initial
  begin
    objRead = 1'b0;
    objWrite = 1'b0;
    objIndex = 16'h0000;
    objWrData = 16'h0000;
  end

  // Callers send reserved function bits as zero
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, output logic err);
    @(posedge clock);
    #1;
    objWrite = 1'b1;
    objIndex = idx;
    objWrData = d;
    @(posedge clock);
    #1;
    objWrite = 1'b0;
    // Released lines must not keep the last value
    objIndex = ~idx;
    objWrData = ~d;
    err = objError_q;
  endtask : wr

  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic err, output logic ok);
    int n;
    @(posedge clock);
    #1;
    objRead = 1'b1;
    objIndex = idx;
    @(posedge clock);
    #1;
    objRead = 1'b0;
    objIndex = ~idx;
    n = 0;
    while (objRdValid_q !== 1'b1 && n < 4)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    ok = (objRdValid_q === 1'b1);
    d = objRdData_q;
    err = objError_q;
  endtask : rd
endmodule : tpl_host_model

// ===== tb/touch_probe_position_latch_tb_top.sv
/*
  Self-checking bench for the two-channel probe latch.
  Assumes the host model drives the object port; the bench drives pins and position.
*/
`timescale 1ns/100ps
module touch_probe_position_latch_tb_top;
  logic clock, sys_rst, pinOne, pinTwo, encIndex, e;
  logic [31:0] pos, rdData;
  logic objRead, objWrite, objRdValid_q, objError_q;
  logic [15:0] objIndex, objWrData;
  logic [31:0] objRdData_q;
  int bad_count, samples_checked;

  always #20 clock = ~clock;

  tpl_probe_latch u_tpl_probe_latch (.clock(clock), .sys_rst(sys_rst), .probe_input_one(pinOne),
    .probe_input_two(pinTwo), .encoderIndex(encIndex), .feedbackPosition(pos), .objRead(objRead),
    .objWrite(objWrite), .objIndex(objIndex), .objWrData(objWrData), .objRdData_q(objRdData_q),
    .objRdValid_q(objRdValid_q), .objError_q(objError_q));
  tpl_host_model u_tpl_host_model (.clock(clock), .objRead(objRead), .objWrite(objWrite),
    .objIndex(objIndex), .objWrData(objWrData), .objRdData_q(objRdData_q),
    .objRdValid_q(objRdValid_q), .objError_q(objError_q));

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input string name);
    logic ok;
    u_tpl_host_model.rd(idx, rdData, e, ok);
    cmp({name, " valid"}, 32'h1, {31'h0, ok});
    cmp(name, exp, rdData);
  endtask : rdc

  // Pins are held well past the one-cycle minimum
  task automatic drive(input logic [31:0] p, input logic a, input logic b, input logic c);
    @(posedge clock);
    #1;
    pos = p;
    pinOne = a;
    pinTwo = b;
    encIndex = c;
    repeat (8) @(posedge clock);
  endtask : drive

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    pinOne = 1'b0;
    pinTwo = 1'b0;
    encIndex = 1'b0;
    pos = 32'h0000_0000;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    rdc(tpl_pkg::OBJ_FUNC, 32'h0000_0000, "func");
    rdc(tpl_pkg::OBJ_STATUS, 32'h0000_0000, "status");
    u_tpl_host_model.wr(tpl_pkg::OBJ_FUNC, 16'h3737, e);
    rdc(tpl_pkg::OBJ_FUNC, 32'h0000_3737, "func");
    $display("test reset and function word done");
    u_tpl_host_model.wr(tpl_pkg::OBJ_FUNC, 16'h0000, e);
    u_tpl_host_model.wr(tpl_pkg::OBJ_FUNC, 16'h0031, e);
    drive(32'h1111_AAAA, 1'b1, 1'b0, 1'b0);
    rdc(tpl_pkg::OBJ_STATUS, 32'h0000_0003, "status");
    rdc(tpl_pkg::OBJ_ONE_RISE, 32'h1111_AAAA, "one rise");
    rdc(tpl_pkg::OBJ_TWO_RISE, 32'h0000_0000, "two rise");
    drive(32'h2222_BBBB, 1'b0, 1'b0, 1'b0);
    rdc(tpl_pkg::OBJ_STATUS, 32'h0000_0007, "status");
    rdc(tpl_pkg::OBJ_ONE_FALL, 32'h2222_BBBB, "one fall");
    drive(32'h3333_CCCC, 1'b1, 1'b0, 1'b0);
    rdc(tpl_pkg::OBJ_ONE_RISE, 32'h1111_AAAA, "one rise");
    u_tpl_host_model.wr(tpl_pkg::OBJ_FUNC, 16'h0000, e);
    rdc(tpl_pkg::OBJ_STATUS, 32'h0000_0000, "status");
    u_tpl_host_model.wr(tpl_pkg::OBJ_FUNC, 16'h0011, e);
    drive(32'h4444_DDDD, 1'b0, 1'b0, 1'b0);
    rdc(tpl_pkg::OBJ_STATUS, 32'h0000_0001, "status");
    drive(32'h5555_EEEE, 1'b1, 1'b0, 1'b0);
    rdc(tpl_pkg::OBJ_ONE_RISE, 32'h5555_EEEE, "one rise");
    $display("test single mode done");
    u_tpl_host_model.wr(tpl_pkg::OBJ_FUNC, 16'h3711, e);
    drive(32'h6666_1234, 1'b1, 1'b0, 1'b1);
    drive(32'h7777_5678, 1'b1, 1'b0, 1'b0);
    rdc(tpl_pkg::OBJ_STATUS, 32'h0000_8703, "status");
    rdc(tpl_pkg::OBJ_TWO_RISE, 32'h6666_1234, "two rise");
    rdc(tpl_pkg::OBJ_TWO_FALL, 32'h7777_5678, "two fall");
    rdc(tpl_pkg::OBJ_ONE_RISE, 32'h5555_EEEE, "one rise");
    drive(32'h0ABC_0001, 1'b1, 1'b0, 1'b1);
    drive(32'h0ABC_0002, 1'b1, 1'b0, 1'b0);
    rdc(tpl_pkg::OBJ_STATUS, 32'h0000_0703, "status");
    rdc(tpl_pkg::OBJ_TWO_RISE, 32'h0ABC_0001, "two rise");
    drive(32'h0DEF_0003, 1'b1, 1'b1, 1'b0);
    rdc(tpl_pkg::OBJ_TWO_RISE, 32'h0ABC_0001, "two rise");
    u_tpl_host_model.wr(tpl_pkg::OBJ_FUNC, 16'h2701, e);
    drive(32'h0DEF_0004, 1'b1, 1'b1, 1'b1);
    rdc(tpl_pkg::OBJ_TWO_RISE, 32'h0ABC_0001, "two rise");
    rdc(tpl_pkg::OBJ_STATUS, 32'h0000_0703, "status");
    $display("test continuous mode done");
    u_tpl_host_model.wr(tpl_pkg::OBJ_STATUS, 16'h0000, e);
    cmp("status write error", 32'h1, {31'h0, e});
    rdc(16'h60BE, 32'h0000_0000, "unknown read");
    cmp("unknown read error", 32'h1, {31'h0, e});
    u_tpl_host_model.wr(tpl_pkg::OBJ_FUNC, 16'h0000, e);
    cmp("func write error", 32'h0, {31'h0, e});
    $display("test refused access done");
    wrap_up();
  end
endmodule : touch_probe_position_latch_tb_top
